/* dv/instruction_word_decoder_asserts.sv */
// Timing checks on the decoder's ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module insn_decode_asserts
   import insn_decode_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic [INSN_W-1:0] insn_in,
   input wire logic prescaler_to_timer_in,
   input wire logic [1:0] quarter_out,
   input wire logic [FADDR_W-1:0] file_addr_out,
   input wire logic dest_file_out,
   input wire logic [LIT8_W-1:0] lit8_out,
   input wire logic is_byte_op_out,
   input wire logic is_bit_op_out,
   input wire logic is_literal_op_out,
   input wire logic file_read_out,
   input wire logic file_write_out,
   input wire logic two_cycle_out,
   input wire logic no_operation_out,
   input wire logic port_mismatch_clear_out,
   input wire logic prescaler_clear_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);
   a_quarter_step: assert property (clk_en_in && $past(clk_en_in) && !$past(sys_rst_in)
      |=> quarter_out == $past(quarter_out) + 2'h1) else $error("quarter skipped");
   a_addr_field: assert property (quarter_out == Q_FIRST && $past(clk_en_in)
      && !no_operation_out && (is_byte_op_out || is_bit_op_out)
      |-> file_addr_out == $past(insn_in[FADDR_HI:FADDR_LO])) else $error("file address wrong");
   a_lit_field: assert property (quarter_out == Q_FIRST && $past(clk_en_in)
      && !no_operation_out && is_literal_op_out
      |-> lit8_out == $past(insn_in[LIT8_HI:0])) else $error("literal wrong");
   a_dest_route: assert property (is_byte_op_out && !no_operation_out
      |-> file_write_out == dest_file_out) else $error("destination wrong");
   a_write_reads: assert property (file_write_out && !no_operation_out
      |-> file_read_out) else $error("write without read");
   a_port_clear: assert property (quarter_out == Q_READ && $past(clk_en_in) && clk_en_in
      |-> port_mismatch_clear_out
      == (file_read_out && file_addr_out == ADDR_UPPER_PORT && !no_operation_out)
      ##1 !port_mismatch_clear_out) else $error("mismatch clear wrong");
   a_timer_clear: assert property (quarter_out == Q_LAST && $past(clk_en_in)
      && !no_operation_out |-> prescaler_clear_out == (file_write_out
      && file_addr_out == ADDR_TIMER_ZERO && $past(prescaler_to_timer_in)))
      else $error("prescaler clear wrong");
   a_flush_nop: assert property (clk_en_in && two_cycle_out && !no_operation_out
      && quarter_out == Q_LAST |=> no_operation_out [*4]) else $error("flush cycle wrong");
endmodule
bind instruction_word_decoder insn_decode_asserts chk (.*);

/* dv/reg_file_model.sv */
// Register file and port pins facing the decoder's read side.
// Assumes the address is held for the whole instruction cycle.
`timescale 1ns/10ps
module reg_file_model
   import insn_decode_pkg::*;
#(
   parameter logic [DATA_W-1:0] PIN_LEVEL = 8'hC3
)(
   input wire logic [FADDR_W-1:0] addr_in,
   output logic [DATA_W-1:0] file_data_out,
   output logic [DATA_W-1:0] pin_level_out
);
   // Latch contents differ from the pins so a wrong read source shows up
   assign file_data_out = {1'b0, addr_in} ^ 8'h5A;
   assign pin_level_out = PIN_LEVEL;
endmodule

/* dv/test_instruction_word_decoder.sv */
// Self-checking bench for the instruction word decoder.
// Assumes reg_file_model answers reads; one word is issued every 8 clocks.
`timescale 1ns/10ps
module test_instruction_word_decoder;
   import insn_decode_pkg::*;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic clk_en_in = 1'b1;
   logic skip_true_in = 1'b0;
   logic prescaler_to_timer_in = 1'b0;
   logic [INSN_W-1:0] insn_in = 14'h0000;
   logic [DATA_W-1:0] pin_level_in, file_data_in, operand_out, lit8_out;
   logic [FADDR_W-1:0] file_addr_out;
   logic [LIT11_W-1:0] lit11_out;
   logic [BITSEL_W-1:0] bit_sel_out;
   logic [1:0] quarter_out;
   logic dest_file_out, is_byte_op_out, is_bit_op_out, is_literal_op_out, is_jump_out;
   logic file_read_out, file_write_out, acc_write_out, two_cycle_out, no_operation_out;
   logic port_mismatch_clear_out, prescaler_clear_out;
   int error_cnt = 0;
   int tests_run = 0;
   localparam logic [DATA_W-1:0] PIN_VAL = 8'hC3;
   instruction_word_decoder dut (.*);
   reg_file_model #(.PIN_LEVEL(PIN_VAL)) partner (.addr_in(file_addr_out),
      .file_data_out(file_data_in), .pin_level_out(pin_level_in));
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Drives one word, then a literal filler that a flush cycle must ignore
   task automatic issue(input logic [INSN_W-1:0] w, input logic sk, input logic ps);
      logic [1:0] c;
      logic [3:0] op;
      logic [3:0] cat;
      logic misc, rd, wr, tp, tc, prt, no_operation;
      c = w[CLASS_HI:CLASS_LO];
      op = w[OP_HI:OP_LO];
      misc = c == CLS_BYTE && op == OPB_MISC && !w[DEST_POS];
      cat = misc ? 4'h1 : 4'h8 >> c;
      no_operation = misc && w[4:0] == 5'h00;
      rd = c == CLS_BIT || (c == CLS_BYTE && (op == OPB_MISC ? w[7] : op != OPB_CLR || w[7]));
      wr = (c == CLS_BYTE && rd && w[7]) || (c == CLS_BIT && !w[11]);
      tp = c == CLS_JUMP || (c == CLS_LIT && w[11:10] == OPL_RETLIT);
      tp = tp || (misc && w[7:1] == 7'h04) || (wr && w[6:0] == ADDR_PCL);
      tc = tp || (sk && (c == CLS_BIT ? w[11] : op == OPB_DECSZ || op == OPB_INCSZ));
      prt = rd && w[6:0] == ADDR_UPPER_PORT;
      @(posedge mclk_in);
      insn_in <= w;
      skip_true_in <= sk;
      prescaler_to_timer_in <= ps;
      repeat (3) @(posedge mclk_in);
      #1;
      check(quarter_out, Q_FIRST);
      check(two_cycle_out, tp);
      check({is_byte_op_out, is_bit_op_out, is_jump_out, is_literal_op_out}, cat);
      check(no_operation_out, no_operation);
      check(file_read_out, rd);
      check(file_write_out, wr);
      if (!c[1]) check(file_addr_out, w[6:0]);
      if (c == CLS_BYTE) check({dest_file_out, file_write_out}, {2{w[7]}});
      if (c == CLS_BYTE && op != OPB_MISC) check(acc_write_out, !w[7]);
      if (c == CLS_BIT) check(bit_sel_out, w[9:7]);
      if (c == CLS_LIT) check(lit8_out, w[7:0]);
      if (c == CLS_JUMP) check(lit11_out, w[10:0]);
      @(posedge mclk_in);
      insn_in <= 14'h3000;
      #1;
      check(operand_out, !rd ? 8'h00 : prt ? PIN_VAL : {1'b0, w[6:0]} ^ 8'h5A);
      check(port_mismatch_clear_out, prt);
      repeat (2) @(posedge mclk_in);
      #1;
      check(prescaler_clear_out, wr && w[6:0] == ADDR_TIMER_ZERO && ps);
      check(two_cycle_out, tc);
      @(posedge mclk_in);
      #1;
      check({no_operation_out, two_cycle_out}, {2{tc}});
   endtask
   // Holds the enable low across the read quarter of a port read
   task automatic freeze_ops();
      @(posedge mclk_in);
      insn_in <= 14'h0886;
      repeat (3) @(posedge mclk_in);
      @(posedge mclk_in);
      clk_en_in <= 1'b0;
      insn_in <= 14'h3000;
      repeat (4) @(posedge mclk_in);
      #1;
      check(quarter_out, Q_READ);
      check({port_mismatch_clear_out, operand_out}, {1'b1, PIN_VAL});
      @(posedge mclk_in);
      clk_en_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      #1;
      check({quarter_out, port_mismatch_clear_out}, {Q_LAST, 1'b0});
      @(posedge mclk_in);
   endtask
   // Reset in mid-run, landing inside the flush cycle of a taken skip
   task automatic reset_ops();
      issue(14'h1C05, 1'b1, 1'b0);
      @(posedge mclk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      #1;
      check({no_operation_out, two_cycle_out}, 2'h2);
      check({port_mismatch_clear_out, prescaler_clear_out, quarter_out}, 4'h0);
      check(operand_out, 8'h00);
      @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic byte_ops();
      issue(14'h0780, 1'b0, 1'b0);
      issue(14'h0782, 1'b0, 1'b0);
      issue(14'h0785, 1'b1, 1'b0);
      issue(14'h077F, 1'b0, 1'b0);
      issue(14'h0100, 1'b0, 1'b0);
      issue(14'h017F, 1'b0, 1'b0);
      issue(14'h0060, 1'b0, 1'b0);
      issue(14'h0186, 1'b0, 1'b0);
      issue(14'h0886, 1'b0, 1'b0);
      issue(14'h0B85, 1'b1, 1'b0);
      issue(14'h0F05, 1'b0, 1'b0);
      issue(14'h0008, 1'b0, 1'b0);
      issue(14'h0009, 1'b0, 1'b0);
   endtask
   task automatic control_ops();
      issue(14'h1390, 1'b0, 1'b0);
      issue(14'h1C05, 1'b1, 1'b0);
      issue(14'h1805, 1'b0, 1'b0);
      issue(14'h30A5, 1'b0, 1'b0);
      issue(14'h3400, 1'b0, 1'b0);
      issue(14'h2FFF, 1'b0, 1'b0);
      issue(14'h2000, 1'b0, 1'b0);
   endtask
   task automatic timer_ops();
      issue(14'h0081, 1'b0, 1'b1);
      issue(14'h0081, 1'b0, 1'b0);
      issue(14'h0181, 1'b0, 1'b1);
      issue(14'h0801, 1'b0, 1'b1);
      issue(14'h1481, 1'b0, 1'b1);
      issue(14'h1881, 1'b0, 1'b1);
   endtask
   initial begin
      repeat (2000) @(posedge mclk_in);
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      #1;
      check({no_operation_out, two_cycle_out}, 2'h2);
      @(posedge mclk_in);
      byte_ops();
      control_ops();
      timer_ops();
      freeze_ops();
      reset_ops();
      conclude();
   end
endmodule

/* hdl/insn_decode_pkg.sv */
// Constants shared by the instruction word decoder and its helpers.
// Assumes a 14-bit instruction word and a 40 MHz oscillator clock.
package insn_decode_pkg;
   localparam int unsigned INSN_W = 14;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned BITSEL_W = 3;
   localparam int unsigned LIT8_W = 8;
   localparam int unsigned LIT11_W = 11;
   localparam int unsigned DATA_W = 8;
   // Field positions
   localparam int unsigned CLASS_HI = 13;
   localparam int unsigned CLASS_LO = 12;
   localparam int unsigned OP_HI = 11;
   localparam int unsigned OP_LO = 8;
   localparam int unsigned DEST_POS = 7;
   localparam int unsigned FADDR_HI = 6;
   localparam int unsigned FADDR_LO = 0;
   localparam int unsigned BIT_HI = 9;
   localparam int unsigned BIT_LO = 7;
   localparam int unsigned BITOP_HI = 11;
   localparam int unsigned BITOP_LO = 10;
   localparam int unsigned LIT8_HI = 7;
   localparam int unsigned LIT11_HI = 10;
   localparam int unsigned JMP_POS = 11;
   // Category codes in bits 13:12
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;
   // Byte-class opcodes in bits 11:8
   localparam logic [3:0] OPB_MISC = 4'h0;
   localparam logic [3:0] OPB_CLR = 4'h1;
   localparam logic [3:0] OPB_DECSZ = 4'hB;
   localparam logic [3:0] OPB_INCSZ = 4'hF;
   // Bit-class opcodes in bits 11:10
   localparam logic [1:0] OPT_SKIPCLR = 2'h2;
   localparam logic [1:0] OPT_SKIPSET = 2'h3;
   // Literal-class return with literal: bits 11:10
   localparam logic [1:0] OPL_RETLIT = 2'h1;
   // Misc words, bits 7:0 with bit 7 clear
   localparam logic [7:0] MISC_RETURN = 8'h08;
   localparam logic [7:0] MISC_RETINT = 8'h09;
   localparam logic [7:0] MISC_SLEEP = 8'h63;
   localparam logic [7:0] MISC_CLRWDT = 8'h64;
   // Destination select values
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_FILE = 1'h1;
   // Addresses of special file registers
   localparam logic [FADDR_W-1:0] ADDR_TIMER_ZERO = 7'h01;
   localparam logic [FADDR_W-1:0] ADDR_PCL = 7'h02;
   localparam logic [FADDR_W-1:0] ADDR_UPPER_PORT = 7'h06;
   // Timing
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned QUARTERS = 4;
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam logic [1:0] Q_READ = 2'h1;
   localparam logic [1:0] Q_MODIFY = 2'h2;
   localparam logic [1:0] Q_LAST = 2'h3;
   typedef enum logic [1:0] {ST_EXEC, ST_FLUSH} cycle_state_t;
endpackage

/* hdl/instruction_word_decoder.sv */
// Instruction word decoder: splits a 14-bit word into operand fields and
// paces execution in four-quarter instruction cycles.
// Assumes fetched words arrive on insn_in and are stable when the first quarter latches them.
//
// Notes on behaviour
// RQ1 - Words are 14 bits, split into a category/opcode part and operand fields.
// RQ2 - Byte operations send the result to the accumulator on d=0 and to the file on d=1.
// RQ3 - The file address is the low seven bits, covering 0x00 to 0x7F.
// RQ4 - Bit operations take a three-bit select naming one bit of the addressed 8-bit register.
// RQ5 - Literal operations yield an eight-bit constant or an eleven-bit jump target.
// RQ6 - One instruction cycle is four oscillator periods and ordinary work ends within it.
// RQ7 - A true skip or a program counter change adds a second cycle executed as no_operation.
// RQ8 - Every file-register instruction reads its register, even when it only writes.
// RQ9 - Clearing upper_port_data also reads it, which clears the port change mismatch.
// RQ10 - Don't-care bits do not change the decoded operation.
// RQ11 - A read-modify-write on a port register reads the pin levels, not the latch.
// RQ12 - Writing timer_zero_count clears the prescaler when it belongs to timer zero.
// RQ13 - Fields and the two-cycle flag are presented in the first quarter of each cycle; a true skip raises the flag only in the last quarter.
`timescale 1ns/10ps
module instruction_word_decoder
   import insn_decode_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic [INSN_W-1:0] insn_in,
   input wire logic skip_true_in,
   input wire logic prescaler_to_timer_in,
   input wire logic [DATA_W-1:0] pin_level_in,
   input wire logic [DATA_W-1:0] file_data_in,
   output logic [1:0] quarter_out,
   output logic [FADDR_W-1:0] file_addr_out,
   output logic dest_file_out,
   output logic [BITSEL_W-1:0] bit_sel_out,
   output logic [LIT8_W-1:0] lit8_out,
   output logic [LIT11_W-1:0] lit11_out,
   output logic is_byte_op_out,
   output logic is_bit_op_out,
   output logic is_literal_op_out,
   output logic is_jump_out,
   output logic file_read_out,
   output logic file_write_out,
   output logic acc_write_out,
   output logic two_cycle_out,
   output logic no_operation_out,
   output logic port_mismatch_clear_out,
   output logic prescaler_clear_out,
   output logic [DATA_W-1:0] operand_out
);
   // ==========================================================
   // State
   typedef struct packed {
      cycle_state_t st;
      logic [1:0] q;
      logic [FADDR_W-1:0] faddr;
      logic dest;
      logic [BITSEL_W-1:0] bsel;
      logic [LIT8_W-1:0] lit8;
      logic [LIT11_W-1:0] lit11;
      logic byte_op;
      logic bit_op;
      logic lit_op;
      logic jump;
      logic frd;
      logic fwr;
      logic awr;
      logic two;
      logic no_operation;
      logic pclr;
      logic prclr;
      logic cskip;
      logic [DATA_W-1:0] opnd;
   } dec_state_t;

   localparam dec_state_t DEC_RESET = '{
      st: ST_EXEC, q: Q_FIRST, faddr: '0, dest: DEST_ACC, bsel: '0,
      lit8: '0, lit11: '0, byte_op: 1'b0, bit_op: 1'b0, lit_op: 1'b0,
      jump: 1'b0, frd: 1'b0, fwr: 1'b0, awr: 1'b0, two: 1'b0,
      no_operation: 1'b1, pclr: 1'b0, prclr: 1'b0, cskip: 1'b0, opnd: '0};

   dec_state_t cur_ff;
   dec_state_t nxt_cur;
   logic [1:0] quarter;
   logic [DATA_W-1:0] read_data;

   // ==========================================================
   // Helpers
   quarter_counter u_quarter (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .quarter_out(quarter)
   );

   rmw_port_select u_rmw_sel (
      .is_port_in(cur_ff.faddr == ADDR_UPPER_PORT),
      .pin_level_in(pin_level_in),
      .file_data_in(file_data_in),
      .read_data_out(read_data)
   );

   // ==========================================================
   // Decode
   logic [1:0] cls;
   logic [3:0] opb;
   logic [1:0] opt;
   logic misc;
   logic uses_file;
   logic writes_file;
   logic pc_change;
   logic cond_skip;
   always_comb begin
      cls = insn_in[CLASS_HI:CLASS_LO]; // RQ1
      opb = insn_in[OP_HI:OP_LO];
      opt = insn_in[BITOP_HI:BITOP_LO];
      misc = (cls == CLS_BYTE) && (opb == OPB_MISC) && !insn_in[DEST_POS];
      // Byte ops with d=0 on the clear opcode are accumulator-only
      uses_file = ((cls == CLS_BYTE) && !misc
                   && !((opb == OPB_CLR) && !insn_in[DEST_POS]))
                  || (cls == CLS_BIT);
      writes_file = ((cls == CLS_BYTE) && uses_file && insn_in[DEST_POS]) // RQ2
                    || ((cls == CLS_BIT) && !opt[1]);
      pc_change = (cls == CLS_JUMP)
                  || ((cls == CLS_LIT) && (opt == OPL_RETLIT))
                  || (misc && ((insn_in[LIT8_HI:0] == MISC_RETURN)
                               || (insn_in[LIT8_HI:0] == MISC_RETINT)))
                  || (writes_file && (insn_in[FADDR_HI:FADDR_LO] == ADDR_PCL));
      cond_skip = ((cls == CLS_BYTE) && ((opb == OPB_DECSZ) || (opb == OPB_INCSZ)))
                  || ((cls == CLS_BIT) && opt[1]);
   end

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.q = quarter;
      nxt_cur.pclr = 1'b0;
      nxt_cur.prclr = 1'b0;
      case (cur_ff.st)
         ST_EXEC: begin
            if (quarter == Q_FIRST) begin
               // Latch fields at the start of the cycle
               nxt_cur.faddr = insn_in[FADDR_HI:FADDR_LO]; // RQ3 RQ13
               nxt_cur.dest = insn_in[DEST_POS]; // RQ2
               nxt_cur.bsel = insn_in[BIT_HI:BIT_LO]; // RQ4
               nxt_cur.lit8 = insn_in[LIT8_HI:0]; // RQ5
               nxt_cur.lit11 = insn_in[LIT11_HI:0]; // RQ5
               nxt_cur.byte_op = (cls == CLS_BYTE) && !misc;
               nxt_cur.bit_op = (cls == CLS_BIT);
               nxt_cur.lit_op = (cls == CLS_LIT) || misc; // RQ10
               nxt_cur.jump = (cls == CLS_JUMP);
               nxt_cur.frd = uses_file; // RQ8
               nxt_cur.fwr = writes_file;
               nxt_cur.awr = ((cls == CLS_BYTE) && !misc && !insn_in[DEST_POS])
                             || ((cls == CLS_LIT) && (opt != OPL_RETLIT));
               nxt_cur.two = pc_change; // RQ13
               // Skip kind is kept: the word may be gone by the last quarter
               nxt_cur.cskip = cond_skip;
               nxt_cur.no_operation = misc && (insn_in[LIT8_HI:0] != MISC_RETURN)
                             && (insn_in[LIT8_HI:0] != MISC_RETINT)
                             && (insn_in[LIT8_HI:0] != MISC_SLEEP)
                             && (insn_in[LIT8_HI:0] != MISC_CLRWDT); // RQ10
            end
            if (quarter == Q_READ) begin
               nxt_cur.opnd = cur_ff.frd ? read_data : '0; // RQ8 RQ11
               // Any file read of the port ends the mismatch, clears included
               nxt_cur.pclr = cur_ff.frd && (cur_ff.faddr == ADDR_UPPER_PORT); // RQ9
            end
            if (quarter == Q_LAST) begin
               nxt_cur.prclr = cur_ff.fwr && (cur_ff.faddr == ADDR_TIMER_ZERO)
                               && prescaler_to_timer_in; // RQ12
               if (cur_ff.two || (cur_ff.cskip && skip_true_in)) begin
                  nxt_cur.two = 1'b1; // RQ7
                  nxt_cur.st = ST_FLUSH;
               end
            end
         end
         ST_FLUSH: begin
            // Second cycle runs as no_operation
            if (quarter == Q_FIRST) begin
               nxt_cur.no_operation = 1'b1; // RQ7
               nxt_cur.frd = 1'b0;
               nxt_cur.fwr = 1'b0;
               nxt_cur.awr = 1'b0;
               nxt_cur.jump = 1'b0;
               nxt_cur.byte_op = 1'b0;
               nxt_cur.bit_op = 1'b0;
               nxt_cur.lit_op = 1'b0;
            end
            if (quarter == Q_LAST) begin
               nxt_cur.two = 1'b0;
               nxt_cur.st = ST_EXEC; // RQ6
            end
         end
         default: nxt_cur.st = ST_EXEC;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cur_ff <= DEC_RESET;
      end else if (clk_en_in) begin
         cur_ff <= nxt_cur;
      end
   end

   // ==========================================================
   // Outputs
   assign quarter_out = cur_ff.q;
   assign file_addr_out = cur_ff.faddr;
   assign dest_file_out = cur_ff.dest;
   assign bit_sel_out = cur_ff.bsel;
   assign lit8_out = cur_ff.lit8;
   assign lit11_out = cur_ff.lit11;
   assign is_byte_op_out = cur_ff.byte_op;
   assign is_bit_op_out = cur_ff.bit_op;
   assign is_literal_op_out = cur_ff.lit_op;
   assign is_jump_out = cur_ff.jump;
   assign file_read_out = cur_ff.frd;
   assign file_write_out = cur_ff.fwr;
   assign acc_write_out = cur_ff.awr;
   assign two_cycle_out = cur_ff.two;
   assign no_operation_out = cur_ff.no_operation;
   assign port_mismatch_clear_out = cur_ff.pclr;
   assign prescaler_clear_out = cur_ff.prclr;
   assign operand_out = cur_ff.opnd;
endmodule

/* hdl/quarter_counter.sv */
// Divides the oscillator clock into the four quarters of one instruction cycle.
// Assumes a synchronous reset and a common clock enable.
`timescale 1ns/10ps
module quarter_counter
   import insn_decode_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   output logic [1:0] quarter_out
);
   typedef struct packed {
      logic [1:0] q;
   } qc_state_t;
   qc_state_t cur_ff;
   qc_state_t nxt_cur;
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.q = (cur_ff.q == Q_LAST) ? Q_FIRST : cur_ff.q + 2'h1;
   end
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cur_ff <= '{q: Q_FIRST};
      end else if (clk_en_in) begin
         cur_ff <= nxt_cur;
      end
   end
   assign quarter_out = cur_ff.q;
endmodule

/* hdl/rmw_port_select.sv */
// Picks the read source for a read-modify-write operand.
// Assumes pin levels and latch values are synchronous to the core clock.
`timescale 1ns/10ps
module rmw_port_select
   import insn_decode_pkg::*;
(
   input wire logic is_port_in,
   input wire logic [DATA_W-1:0] pin_level_in,
   input wire logic [DATA_W-1:0] file_data_in,
   output logic [DATA_W-1:0] read_data_out
);
   // Port registers read back the pins, not the output latch
   assign read_data_out = is_port_in ? pin_level_in : file_data_in; // RQ11
endmodule
